// >>> hdl/lvw_top.v
// low-voltage detect, supervisory resets and watchdog control
// Notes on behaviour
// [R1] supply integrity enable raises irq on flags
// [R2] low-voltage status read-only, follows analog supply
// [R3] low-voltage enable gates change flag irq
// [R4] change flag sets on any status change
// [R5] change flag cleared by writing one
// [R6] enable and flag writable, all readable anytime
// [R7] pll loss or slow clock gives reset
// [R8] full stop disables pll monitor reset
// [R9] unserviced watchdog timeout gives system reset
// [R10] two select bits choose watchdog clock
// [R11] autonomous suppressed clock resumes after sync latency
// [R12] upper select one: run unless suppressed
// [R13] upper select zero: oscillator run conditions
`timescale 1ns/1ps
`include "lvw_defines.vh"
module lvw_top (
   // clock and reset
   input wire mclk_i,
   input wire sys_rst_i,
   // apb slave
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   output wire pready_o,
   output wire pslverr_o,
   output reg [31:0] prdata_o,
   // analog monitors
   input wire analog_supply_low_i,
   input wire supply_short_flag_one_i,
   input wire supply_short_flag_two_i,
   input wire supply_undervolt_flag_one_i,
   input wire supply_undervolt_flag_two_i,
   // clocks seen as sampled levels
   input wire pll_clock_i,
   input wire pll_below_fail_i,
   input wire autonomous_clock_i,
   input wire internal_rc_clock_i,
   input wire oscillator_clock_i,
   // mode and oscillator state
   input wire stop_mode_i,
   input wire full_stop_i,
   input wire oscillator_enable_bit_i,
   input wire oscillator_qualified_i,
   // outputs
   output wire irq_o,
   output wire pll_monitor_rst_o,
   output wire watchdog_rst_o,
   output wire wd_running_o,
   output wire [1:0] wd_clock_src_o
);
   // sync the monitor, clock and mode pins; apb, oscillator enable and qualified inputs are not synced
   wire [11:0] pin_sync;
   lvw_sync3 #(.W(12)) u_sync (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .async_i({analog_supply_low_i, supply_short_flag_one_i,
         supply_short_flag_two_i, supply_undervolt_flag_one_i,
         supply_undervolt_flag_two_i, pll_clock_i, pll_below_fail_i,
         autonomous_clock_i, internal_rc_clock_i, oscillator_clock_i,
         stop_mode_i, full_stop_i}),
      .sync_o(pin_sync)
   );
   wire lv_s = pin_sync[11];
   wire [3:0] si_s = pin_sync[10:7];
   wire pll_clk_s = pin_sync[6];
   wire pll_slow_s = pin_sync[5];
   wire aclk_s = pin_sync[4];
   wire irc_s = pin_sync[3];
   wire osc_s = pin_sync[2];
   wire stop_s = pin_sync[1];
   wire fstop_s = pin_sync[0];

   // apb decode; zero wait states
   wire wr = psel_i & penable_i & pwrite_i;
   wire hit_lv = (paddr_i == `LVW_ADDR_LVCTL);
   wire hit_cfg = (paddr_i == `LVW_ADDR_WDCFG);
   wire hit_svc = (paddr_i == `LVW_ADDR_WDSVC);
   wire hit_rst = (paddr_i == `LVW_ADDR_RSTST);
   wire hit_ist = (paddr_i == `LVW_ADDR_IRQST);
   wire hit_msk = (paddr_i == `LVW_ADDR_IRQMSK);
   wire mapped = hit_lv | hit_cfg | hit_svc | hit_rst | hit_ist | hit_msk;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~mapped;

   // low_voltage_control
   reg lv_stat_reg;
   reg lv_flag_reg;
   reg lv_ie_reg;
   reg si_ie_reg;
   reg [3:0] si_prev_reg;
   wire lv_change = lv_s ^ lv_stat_reg;
   wire lv_clr = wr & hit_lv & pwdata_i[`LVW_LV_FLAG];
   wire [3:0] si_rise = si_s & ~si_prev_reg;
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         lv_stat_reg <= 1'b0;
         lv_flag_reg <= 1'b0;
         lv_ie_reg <= 1'b0;
         si_ie_reg <= 1'b0;
         si_prev_reg <= 4'h0;
      end else begin
         lv_stat_reg <= lv_s; // [R2]
         si_prev_reg <= si_s;
         // set beats clear in the same cycle
         if (lv_change)
            lv_flag_reg <= 1'b1; // [R4]
         else if (lv_clr)
            lv_flag_reg <= 1'b0; // [R5]
         if (wr & hit_lv) begin
            lv_ie_reg <= pwdata_i[`LVW_LV_IE]; // [R6]
            si_ie_reg <= pwdata_i[`LVW_SI_IE];
         end
      end
   end

   // watchdog config
   reg [7:0] wdcfg_reg;
   wire sel_lo = wdcfg_reg[`LVW_WD_SEL_LO];
   wire sel_hi = wdcfg_reg[`LVW_WD_SEL_HI];
   wire supp = wdcfg_reg[`LVW_WD_SUPP];
   wire pstop = wdcfg_reg[`LVW_WD_PSTOP];
   wire keep = wdcfg_reg[`LVW_WD_KEEP];
   wire wd_en = wdcfg_reg[`LVW_WD_EN];
   always @(posedge mclk_i) begin
      if (sys_rst_i)
         wdcfg_reg <= `LVW_WDCFG_RST;
      else if (wr & hit_cfg)
         wdcfg_reg <= pwdata_i[7:0];
   end

   // clock source: 2 autonomous, 1 oscillator, 0 rc
   wire [1:0] src = sel_hi ? 2'h2 : (sel_lo ? 2'h1 : 2'h0); // [R10]
   assign wd_clock_src_o = src;
   reg src_clk;
   always @* begin
      case (src)
         2'h2: src_clk = aclk_s;
         2'h1: src_clk = osc_s;
         default: src_clk = irc_s;
      endcase
   end

   // stop-mode run decision
   function stop_run;
      input hi, sp, ps, kp, lo, oe, oq;
      begin
         if (hi)
            stop_run = ~sp; // [R12]
         else
            stop_run = ps & kp & lo & oe & oq; // [R13]
      end
   endfunction
   wire run_in_stop = stop_run(sel_hi, supp, pstop, keep, sel_lo,
      oscillator_enable_bit_i, oscillator_qualified_i);

   // resume latency after stop for suppressed autonomous clock
   reg stop_d_reg;
   reg [7:0] lat_reg;
   localparam [7:0] LAT_CYC = `LVW_SYNC_LAT_CYC;
   wire stop_exit = stop_d_reg & ~stop_s;
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         stop_d_reg <= 1'b0;
         lat_reg <= 8'h00;
      end else begin
         stop_d_reg <= stop_s;
         if (stop_exit & sel_hi & supp)
            lat_reg <= LAT_CYC; // [R11]
         else if (lat_reg != 8'h00)
            lat_reg <= lat_reg - 8'h01;
      end
   end
   wire wd_active = wd_en & (stop_s ? run_in_stop : (lat_reg == 8'h00));
   assign wd_running_o = wd_active;

   // watchdog counter; counts rising edges of chosen clock
   reg src_d_reg;
   reg [15:0] wd_cnt_reg;
   reg wd_fire_reg;
   wire tick = src_clk & ~src_d_reg;
   wire svc = wr & hit_svc & (pwdata_i == `LVW_WD_KEY);
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         src_d_reg <= 1'b0;
         wd_cnt_reg <= 16'h0000;
         wd_fire_reg <= 1'b0;
      end else begin
         src_d_reg <= src_clk;
         wd_fire_reg <= 1'b0;
         if (svc)
            wd_cnt_reg <= 16'h0000;
         else if (wd_active & tick) begin
            if (wd_cnt_reg == `LVW_WD_TIMEOUT) begin
               wd_fire_reg <= 1'b1; // [R9]
               wd_cnt_reg <= 16'h0000;
            end else
               wd_cnt_reg <= wd_cnt_reg + 16'h0001;
         end
      end
   end

   // pll monitor: missing edges or slow flag
   reg pll_d_reg;
   reg [7:0] miss_reg;
   reg pll_fire_reg;
   wire pll_edge = pll_clk_s ^ pll_d_reg;
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         pll_d_reg <= 1'b0;
         miss_reg <= 8'h00;
         pll_fire_reg <= 1'b0;
      end else begin
         pll_d_reg <= pll_clk_s;
         pll_fire_reg <= 1'b0;
         if (fstop_s | pll_edge)
            miss_reg <= 8'h00; // [R8]
         else if (miss_reg != `LVW_PLL_MISS)
            miss_reg <= miss_reg + 8'h01;
         if (~fstop_s & ((miss_reg == `LVW_PLL_MISS) | pll_slow_s)) begin
            pll_fire_reg <= 1'b1; // [R7]
            miss_reg <= 8'h00;
         end
      end
   end

   // reset stretchers so the system sees a clean pulse
   reg [3:0] pll_rst_cnt_reg;
   reg [3:0] wd_rst_cnt_reg;
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         pll_rst_cnt_reg <= 4'h0;
         wd_rst_cnt_reg <= 4'h0;
      end else begin
         if (pll_fire_reg)
            pll_rst_cnt_reg <= `LVW_RST_PULSE;
         else if (pll_rst_cnt_reg != 4'h0)
            pll_rst_cnt_reg <= pll_rst_cnt_reg - 4'h1;
         if (wd_fire_reg)
            wd_rst_cnt_reg <= `LVW_RST_PULSE;
         else if (wd_rst_cnt_reg != 4'h0)
            wd_rst_cnt_reg <= wd_rst_cnt_reg - 4'h1;
      end
   end
   assign pll_monitor_rst_o = (pll_rst_cnt_reg != 4'h0);
   assign watchdog_rst_o = (wd_rst_cnt_reg != 4'h0);

   // sticky event status, write one to clear, set wins
   reg [3:0] ist_reg;
   reg [3:0] msk_reg;
   reg [1:0] rcause_reg;
   wire [3:0] ev = {|si_rise, lv_change, wd_fire_reg, pll_fire_reg};
   wire [3:0] iclr = (wr & hit_ist) ? pwdata_i[3:0] : 4'h0;
   wire [1:0] rclr = (wr & hit_rst) ? pwdata_i[1:0] : 2'h0;
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         ist_reg <= 4'h0;
         msk_reg <= 4'h0;
         rcause_reg <= 2'h0;
      end else begin
         ist_reg <= ev | (ist_reg & ~iclr);
         rcause_reg <= {wd_fire_reg, pll_fire_reg} | (rcause_reg & ~rclr);
         if (wr & hit_msk)
            msk_reg <= pwdata_i[3:0];
      end
   end
   // block enables gate the direct sources; mask gates sticky status
   wire lv_req = lv_ie_reg & lv_flag_reg; // [R3]
   wire si_req = si_ie_reg & (|si_s); // [R1]
   assign irq_o = lv_req | si_req | (|(ist_reg & msk_reg));

   // read mux, registered data
   always @(posedge mclk_i) begin
      if (sys_rst_i)
         prdata_o <= 32'h0000_0000;
      else if (psel_i & ~penable_i & ~pwrite_i) begin
         prdata_o <= 32'h0000_0000;
         if (hit_lv)
            prdata_o <= {28'h0000000, si_ie_reg, lv_stat_reg, lv_ie_reg,
               lv_flag_reg}; // [R6]
         else if (hit_cfg)
            prdata_o <= {24'h000000, wdcfg_reg};
         else if (hit_svc)
            prdata_o <= {16'h0000, wd_cnt_reg};
         else if (hit_rst)
            prdata_o <= {30'h00000000, rcause_reg};
         else if (hit_ist)
            prdata_o <= {28'h0000000, ist_reg};
         else if (hit_msk)
            prdata_o <= {28'h0000000, msk_reg};
      end
   end
endmodule // lvw_top

// >>> inc/lvw_defines.vh
// register map, field positions, reset values and timing for lvw block
`ifndef LVW_DEFINES_VH
`define LVW_DEFINES_VH

// byte addresses
`define LVW_ADDR_LVCTL 12'h000
`define LVW_ADDR_WDCFG 12'h004
`define LVW_ADDR_WDSVC 12'h008
`define LVW_ADDR_RSTST 12'h00C
`define LVW_ADDR_IRQST 12'h010
`define LVW_ADDR_IRQMSK 12'h014

// low_voltage_control fields
`define LVW_LV_FLAG 0
`define LVW_LV_IE 1
`define LVW_LV_STAT 2
`define LVW_SI_IE 3

// watchdog config fields
`define LVW_WD_SEL_LO 0
`define LVW_WD_SEL_HI 1
`define LVW_WD_SUPP 2
`define LVW_WD_PSTOP 3
`define LVW_WD_KEEP 4
`define LVW_WD_EN 5
`define LVW_WDCFG_RST 8'h00

// watchdog service key
`define LVW_WD_KEY 32'h0000_00A5

// status fields (reset causes and irq status)
`define LVW_ST_PLL 0
`define LVW_ST_WD 1
`define LVW_ST_LV 2
`define LVW_ST_SI 3

// timing
`define LVW_WD_TIMEOUT 16'hFFFF
`define LVW_SYNC_LAT_NS 40
`define LVW_CLK_NS 5
`define LVW_SYNC_LAT_CYC ((`LVW_SYNC_LAT_NS + `LVW_CLK_NS - 1) / `LVW_CLK_NS)
`define LVW_PLL_MISS 8'h20
`define LVW_RST_PULSE 4'hF

`endif

// >>> hdl/lvw_sync3.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module lvw_sync3 #(
   parameter W = 1
) (
   // clock and reset
   input wire mclk_i,
   input wire sys_rst_i,
   // data
   input wire [W-1:0] async_i,
   output wire [W-1:0] sync_o
);
   reg [W-1:0] s1_reg;
   reg [W-1:0] s2_reg;
   reg [W-1:0] s3_reg;
   reg [W-1:0] out_reg;
   // first stage feeds only the second
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         s1_reg <= {W{1'b0}};
         s2_reg <= {W{1'b0}};
         s3_reg <= {W{1'b0}};
         out_reg <= {W{1'b0}};
      end else begin
         s1_reg <= async_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         out_reg <= (s2_reg & s3_reg) | (out_reg & (s2_reg | s3_reg));
      end
   end
   assign sync_o = out_reg;
endmodule // lvw_sync3

// >>> verif/lvw_checker.sv
// port assertions for the low-voltage and watchdog block
`timescale 1ns/1ps
module lvw_checker (
   // clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // apb
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // pins
   input wire logic analog_supply_low_i,
   input wire logic full_stop_i,
   input wire logic irq_o,
   input wire logic pll_monitor_rst_o,
   input wire logic watchdog_rst_o,
   input wire logic [1:0] wd_clock_src_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   wire acc = psel_i && penable_i;
   wire rd0 = acc && !pwrite_i && paddr_i == 12'h000;
   property p_ready; acc |-> pready_o; endproperty
   property p_err_hi; acc && paddr_i > 12'h014 |-> pslverr_o; endproperty
   property p_err_lo;
      acc && paddr_i <= 12'h014 && paddr_i[1:0] == 2'b00 |-> !pslverr_o;
   endproperty
   property p_src; wd_clock_src_o != 2'b11; endproperty
   property p_rst;
      $fell(sys_rst_i) |-> !irq_o && !pll_monitor_rst_o && !watchdog_rst_o;
   endproperty
   property p_pll; $rose(pll_monitor_rst_o) |-> pll_monitor_rst_o [*8];
   endproperty
   property p_wd; $rose(watchdog_rst_o) |-> watchdog_rst_o [*8]; endproperty
   property p_stop; full_stop_i [*8] |-> !$rose(pll_monitor_rst_o);
   endproperty
   // status settles through the input synchroniser first
   property p_stat;
      $stable(analog_supply_low_i) [*8] ##0 rd0
         |-> prdata_o[2] == analog_supply_low_i;
   endproperty
   a_ready: assert property (p_ready)
      else $error("pready low in access");
   a_err_hi: assert property (p_err_hi)
      else $error("no error on unmapped access");
   a_err_lo: assert property (p_err_lo)
      else $error("error on mapped access");
   a_src: assert property (p_src)
      else $error("illegal clock source code");
   a_rst: assert property (p_rst)
      else $error("output high after reset");
   a_pll: assert property (p_pll)
      else $error("pll reset pulse too short");
   a_wd: assert property (p_wd)
      else $error("watchdog reset pulse too short");
   a_stop: assert property (p_stop)
      else $error("pll reset in full stop");
   a_stat: assert property (p_stat)
      else $error("status bit differs from supply");
   c_pll: cover property ($rose(pll_monitor_rst_o));
   c_irq: cover property ($rose(irq_o));
   c_err: cover property (acc && pslverr_o);
endmodule // lvw_checker

// >>> verif/testbench.sv
// self-checking bench for the low-voltage and watchdog block
`timescale 1ns/1ps
module testbench;
   typedef struct packed {
      logic [11:0] a;
      logic w;
      logic [31:0] d;
      logic [31:0] e;
      logic er;
   } lvw_row_t;
   logic mclk_i = 0, sys_rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rd, c;
   logic pready_o, pslverr_o, irq_o, pll_monitor_rst_o, watchdog_rst_o, err;
   logic wd_running_o, analog_supply_low_i = 0, full_stop_i = 0;
   logic stop_mode_i = 0, pll_below_fail_i = 0, pll_run = 1;
   logic osc_en = 0, osc_ok = 0;
   logic [1:0] wd_clock_src_o;
   logic [3:0] sfl = 4'h0, tick = 4'h0;
   int fail_count = 0, checks_done = 0, cyc = 0;
   lvw_row_t rows [7] = '{
      '{12'h000, 1'b0, 32'h0, 32'h0, 1'b0},
      '{12'h004, 1'b0, 32'h0, 32'h0, 1'b0},
      '{12'h014, 1'b0, 32'h0, 32'h0, 1'b0},
      '{12'h000, 1'b1, 32'h0000000E, 32'h0, 1'b0},
      '{12'h000, 1'b0, 32'h0, 32'h0000000A, 1'b0},
      '{12'h004, 1'b1, 32'h0000003F, 32'h0, 1'b0},
      '{12'h020, 1'b0, 32'h0, 32'h0, 1'b1}};
   lvw_top DUT (.mclk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i,
      .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .prdata_o,
      .analog_supply_low_i, .supply_short_flag_one_i(sfl[0]),
      .supply_short_flag_two_i(sfl[1]), .supply_undervolt_flag_one_i(sfl[2]),
      .supply_undervolt_flag_two_i(sfl[3]), .pll_clock_i(pll_run & tick[1]),
      .pll_below_fail_i, .autonomous_clock_i(tick[2]),
      .internal_rc_clock_i(tick[2]), .oscillator_clock_i(tick[3]),
      .stop_mode_i, .full_stop_i, .oscillator_enable_bit_i(osc_en),
      .oscillator_qualified_i(osc_ok), .irq_o, .pll_monitor_rst_o,
      .watchdog_rst_o, .wd_running_o, .wd_clock_src_o);
   initial forever #2.5 mclk_i = ~mclk_i;
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // slow clocks kept at or under mclk/4 so edges are seen
   always @(posedge mclk_i) begin
      tick <= tick + 4'h1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         end_sim;
      end
   end
   task automatic check(input string nm, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   task automatic apb(input logic [11:0] a, input logic w,
      input logic [31:0] d);
      @(posedge mclk_i);
      psel_i <= 1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1;
      do @(posedge mclk_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
   endtask
   initial begin
      wait_cyc(3);
      sys_rst_i <= 0;
      foreach (rows[i]) begin
         apb(rows[i].a, rows[i].w, rows[i].d);
         check("pslverr", err, rows[i].er);
         if (!rows[i].w) check("prdata", rd, rows[i].e);
      end
      for (int i = 0; i < 4; i++) begin
         apb(12'h004, 1, i);
         #1 check("src", wd_clock_src_o, (i > 1) ? 2 : i);
      end
      $display("register rows done");
      apb(12'h000, 1, 32'h2);
      analog_supply_low_i <= 1;
      wait_cyc(10);
      apb(12'h000, 0, 0);
      check("lvctl", rd, 32'h7);
      #1 check("irq", irq_o, 1);
      apb(12'h000, 1, 32'h2);
      apb(12'h000, 0, 0);
      check("lvctl", rd, 32'h7);
      apb(12'h000, 1, 32'h3);
      apb(12'h000, 0, 0);
      check("lvctl", rd, 32'h6);
      #1 check("irq", irq_o, 0);
      apb(12'h000, 1, 32'h0);
      analog_supply_low_i <= 0;
      wait_cyc(10);
      apb(12'h000, 0, 0);
      check("lvctl", rd, 32'h1);
      #1 check("irq", irq_o, 0);
      apb(12'h000, 1, 32'h9);
      for (int i = 0; i < 4; i++) begin
         sfl <= 4'h1 << i;
         wait_cyc(8);
         check("irq", irq_o, 1);
         sfl <= 4'h0;
         wait_cyc(8);
         check("irq", irq_o, 0);
      end
      apb(12'h000, 1, 32'h0);
      $display("low-voltage tests done");
      pll_run <= 0;
      for (int n = 0; n < 80 && pll_monitor_rst_o !== 1; n++) wait_cyc(1);
      check("pll", pll_monitor_rst_o, 1);
      pll_run <= 1;
      wait_cyc(20);
      pll_below_fail_i <= 1;
      for (int n = 0; n < 80 && pll_monitor_rst_o !== 1; n++) wait_cyc(1);
      check("pll", pll_monitor_rst_o, 1);
      pll_below_fail_i <= 0;
      wait_cyc(20);
      apb(12'h00C, 0, 0);
      check("cause", rd & 32'h1, 1);
      apb(12'h014, 1, 32'h1);
      #1 check("irq", irq_o, 1);
      apb(12'h010, 1, 32'h1);
      #1 check("irq", irq_o, 0);
      apb(12'h014, 1, 32'h0);
      full_stop_i <= 1;
      pll_run <= 0;
      wait_cyc(80);
      check("pll", pll_monitor_rst_o, 0);
      pll_run <= 1;
      wait_cyc(4);
      full_stop_i <= 0;
      $display("pll tests done");
      apb(12'h004, 1, 32'h22);
      wait_cyc(40);
      check("run", wd_running_o, 1);
      apb(12'h008, 0, 0);
      c = rd;
      apb(12'h008, 1, 32'hA5);
      apb(12'h008, 0, 0);
      check("svc", rd < c, 1);
      check("wdrst", watchdog_rst_o, 0);
      stop_mode_i <= 1;
      // stop pin needs the synchroniser delay before it counts
      wait_cyc(8);
      check("run", wd_running_o, 1);
      apb(12'h004, 1, 32'h26);
      wait_cyc(4);
      check("run", wd_running_o, 0);
      stop_mode_i <= 0;
      wait_cyc(8);
      check("run", wd_running_o, 0);
      wait_cyc(20);
      check("run", wd_running_o, 1);
      apb(12'h004, 1, 32'h39);
      osc_en <= 1;
      osc_ok <= 1;
      stop_mode_i <= 1;
      wait_cyc(8);
      check("run", wd_running_o, 1);
      osc_ok <= 0;
      wait_cyc(4);
      check("run", wd_running_o, 0);
      stop_mode_i <= 0;
      $display("watchdog tests done");
      end_sim;
   end
endmodule // testbench
bind lvw_top lvw_checker u_chk (.mclk_i, .sys_rst_i, .psel_i, .penable_i,
   .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o,
   .analog_supply_low_i, .full_stop_i, .irq_o, .pll_monitor_rst_o,
   .watchdog_rst_o, .wd_clock_src_o);
